/* File: iobf_exec.sv */
// Four-phase decode and execute of indexed bit-set and fill-ones instructions
`timescale 1ns/1ps
module iobf_exec
    import iobf_pkg::*;
(
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic clk_en_in,
    input wire logic extension_enable_bit_in,
    input wire logic instr_valid_in,
    input wire logic [15:0] instr_word_in,
    input wire logic [ADDR_W-1:0] frame_pointer_reg_in,
    input wire logic [7:0] mem_rdata_in,
    output logic [1:0] phase_out,
    output logic [ADDR_W-1:0] mem_addr_out,
    output logic mem_rd_out,
    output logic mem_wr_out,
    output logic [7:0] mem_wdata_out,
    output logic busy_out,
    output logic done_out
);
    iobf_phase_t phase_reg;
    iobf_op_t op_reg;
    logic [2:0] bit_reg;
    logic [7:0] data_reg;
    iobf_op_t op_next;

    // Offset field must fit the indexed window
    function automatic logic iobf_offset_ok(input logic [15:0] w);
        return w[OFS_HI:OFS_LO] <= OFS_MAX; // RULE1 RULE7
    endfunction

    // Upper nibble selects the bit-set form, the bit below the bit number must be clear
    function automatic logic iobf_is_bset(input logic [15:0] w);
        return w[BSET_OPC_HI:BSET_OPC_LO] == BSET_OPC && !w[BSET_Z_POS]; // RULE2
    endfunction

    // The whole upper byte names the fill form
    function automatic logic iobf_is_fill(input logic [15:0] w);
        return w[BSET_OPC_HI:OFS_HI+1] == FILL_OPC; // RULE4
    endfunction

    function automatic iobf_op_t iobf_decode(input logic [15:0] w, input logic en);
        iobf_op_t r;
        r = IOBF_OP_NONE;
        if (en && iobf_offset_ok(w)) begin // RULE7 RULE8
            if (iobf_is_bset(w)) begin // RULE2
                r = IOBF_OP_BSET;
            end else if (iobf_is_fill(w)) begin // RULE4
                r = IOBF_OP_FILL;
            end
        end
        return r;
    endfunction

    always_comb begin
        op_next = iobf_decode(instr_word_in, extension_enable_bit_in);
    end

    // Phase sequencer; idle in Q1 until a decodable instruction is offered
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            phase_reg <= IOBF_Q1;
        end else if (clk_en_in) begin
            case (phase_reg)
                IOBF_Q1: begin
                    if (instr_valid_in && op_next != IOBF_OP_NONE) begin
                        phase_reg <= IOBF_Q2; // RULE6
                    end
                end
                IOBF_Q2: phase_reg <= IOBF_Q3;
                IOBF_Q3: phase_reg <= IOBF_Q4;
                IOBF_Q4: phase_reg <= IOBF_Q1;
                default: phase_reg <= IOBF_Q1;
            endcase
        end
    end

    // Byte address of the operand: frame pointer plus zero-extended offset
    function automatic logic [ADDR_W-1:0] iobf_target(
        input logic [ADDR_W-1:0] base,
        input logic [15:0] w
    );
        logic [ADDR_W-1:0] ofs;
        ofs = {{(ADDR_W-8){1'b0}}, w[OFS_HI:OFS_LO]};
        return base + ofs; // RULE1 RULE5
    endfunction

    // One-hot mask of the selected bit
    function automatic logic [7:0] iobf_bit_mask(input logic [2:0] b);
        logic [7:0] m;
        m = 8'h01 << b;
        return m;
    endfunction

    // New byte for the write phase
    function automatic logic [7:0] iobf_result(
        input iobf_op_t op,
        input logic [7:0] old_byte,
        input logic [2:0] b
    );
        logic [7:0] r;
        r = old_byte | iobf_bit_mask(b); // RULE2
        if (op == IOBF_OP_FILL) begin
            r = FILL_VAL; // RULE3
        end
        return r;
    endfunction

    // An instruction is taken only from idle with a decodable word
    logic accept;
    always_comb begin
        accept = clk_en_in && phase_reg == IOBF_Q1 && instr_valid_in
            && op_next != IOBF_OP_NONE;
    end

    // Decoded operation, held for the rest of the cycle
    // Refused words leave it alone so a stale strobe cannot reuse them
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            op_reg <= IOBF_OP_NONE;
        end else if (accept) begin
            op_reg <= op_next;
        end
    end

    // Bit number of the set operation
    // Fill words load it too; it is simply unused for them
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            bit_reg <= 3'h0;
        end else if (accept) begin
            bit_reg <= instr_word_in[BSET_BIT_HI:BSET_BIT_LO];
        end
    end

    // Operand address, sampled with the word
    // Held until the next accepted instruction so memory sees a steady address
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            mem_addr_out <= ADDR_RST;
        end else if (accept) begin
            mem_addr_out <= iobf_target(frame_pointer_reg_in, instr_word_in); // RULE1 RULE5
        end
    end

    // Read request in the read phase
    // Only the bit-set needs the old byte; the fill never reads
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            mem_rd_out <= 1'b0;
        end else if (clk_en_in) begin
            mem_rd_out <= accept && op_next == IOBF_OP_BSET;
        end
    end

    // Old byte, taken while the read request stands
    // Taken for the fill as well; the result ignores it then
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            data_reg <= DATA_RST;
        end else if (clk_en_in && phase_reg == IOBF_Q2) begin
            data_reg <= mem_rdata_in;
        end
    end

    // Write data, formed in the process phase
    // Stays after the strobe so a slow memory can still take it
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            mem_wdata_out <= DATA_RST;
        end else if (clk_en_in && phase_reg == IOBF_Q3) begin
            mem_wdata_out <= iobf_result(op_reg, data_reg, bit_reg); // RULE2 RULE3
        end
    end

    // Write strobe, one cycle in the write phase
    // Only accepted work reaches Q3, so no extra qualifier is needed
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            mem_wr_out <= 1'b0;
        end else if (clk_en_in) begin
            mem_wr_out <= phase_reg == IOBF_Q3;
        end
    end

    // Phase seen from outside, one cycle behind the sequencer
    // No arithmetic flag is produced anywhere in this block
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            phase_out <= 2'b00;
        end else if (clk_en_in) begin
            phase_out <= phase_reg; // RULE6
        end
    end

    // Busy from acceptance until the cycle closes
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            busy_out <= 1'b0;
        end else if (clk_en_in) begin
            busy_out <= phase_reg != IOBF_Q1 || accept;
        end
    end

    // Completion pulse once the write phase is over
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            done_out <= 1'b0;
        end else if (clk_en_in) begin
            done_out <= phase_reg == IOBF_Q4; // RULE6
        end
    end
endmodule

/* File: iobf_pkg.sv */
// Constants and types for the indexed bit-set and fill-ones execution block
// What this block does
// RULE1: Target address is frame pointer plus literal offset k, k from 0 to 95.
// RULE2: Indexed bit-set word 1000 bbb0 kkkk kkkk sets bit b, others unchanged.
// RULE3: Indexed fill writes FFh into the byte at frame pointer plus offset.
// RULE4: Fill is recognised by upper byte 0110 1000; lower byte holds the offset.
// RULE5: Fill target is frame pointer plus offset, never a fixed access-bank byte.
// RULE6: One word, one four-phase cycle, arithmetic status flags left untouched.
// RULE7: With extension on, access-bank offsets up to 5Fh index the frame pointer.
// RULE8: Extension and indexed mode are off when the enable bit is zero.
package iobf_pkg;
    localparam int ADDR_W = 12;
    localparam logic [3:0] BSET_OPC = 4'h8;
    localparam int BSET_OPC_HI = 15;
    localparam int BSET_OPC_LO = 12;
    localparam int BSET_BIT_HI = 11;
    localparam int BSET_BIT_LO = 9;
    localparam int BSET_Z_POS = 8;
    localparam logic [7:0] FILL_OPC = 8'h68;
    localparam int OFS_HI = 7;
    localparam int OFS_LO = 0;
    localparam logic [7:0] OFS_MAX = 8'h5f;
    localparam logic [7:0] FILL_VAL = 8'hff;
    localparam logic [ADDR_W-1:0] ADDR_RST = 12'h000;
    localparam logic [7:0] DATA_RST = 8'h00;
    typedef enum logic [1:0] {
        IOBF_Q1 = 2'b00,
        IOBF_Q2 = 2'b01,
        IOBF_Q3 = 2'b11,
        IOBF_Q4 = 2'b10
    } iobf_phase_t;
    typedef enum logic [1:0] {
        IOBF_OP_NONE = 2'b00,
        IOBF_OP_BSET = 2'b01,
        IOBF_OP_FILL = 2'b10
    } iobf_op_t;
endpackage

/* File: iobf_exec_properties.sv */
// Port checker for the indexed bit-set and fill block
`timescale 1ns/1ps
module iobf_exec_properties
    import iobf_pkg::*;
(
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic extension_enable_bit_in,
    input wire logic mem_rd_out,
    input wire logic mem_wr_out,
    input wire logic busy_out,
    input wire logic done_out,
    input wire logic [7:0] mem_rdata_in,
    input wire logic [7:0] mem_wdata_out,
    input wire logic [ADDR_W-1:0] mem_addr_out,
    input wire logic [ADDR_W-1:0] frame_pointer_reg_in
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    AST_SET: assert property (mem_rd_out |-> ##2 mem_wr_out &&
        (mem_wdata_out | $past(mem_rdata_in, 2)) == mem_wdata_out) else $error("bit set data");
    AST_FILL: assert property (mem_wr_out && !$past(mem_rd_out, 2) |->
        mem_wdata_out == FILL_VAL) else $error("fill data");
    AST_DONE: assert property (mem_wr_out |=> done_out && !mem_wr_out)
        else $error("done late");
    AST_HOLD: assert property (mem_rd_out |=> $stable(mem_addr_out) [*2])
        else $error("address moved");
    AST_OFS: assert property (mem_wr_out |->
        mem_addr_out - $past(frame_pointer_reg_in, 3) <= 12'(OFS_MAX)) else $error("offset");
    AST_EN: assert property (mem_rd_out |-> $past(extension_enable_bit_in, 1))
        else $error("disabled");
    AST_GAP: assert property (done_out |=> !done_out [*3]) else $error("done gap");
    AST_BUSY: assert property (mem_rd_out |-> busy_out && !done_out) else $error("busy");
    cover property (mem_rd_out ##2 mem_wr_out);
    cover property (mem_wr_out && mem_wdata_out == FILL_VAL);
    cover property (done_out ##4 done_out);
endmodule

/* File: test_iobf_exec.sv */
// Self-checking bench for the indexed bit-set and fill block
`timescale 1ns/1ps
module test_iobf_exec;
    logic clk_in = 0, sys_rst_in = 1, clk_en_in = 1, extension_enable_bit_in = 1;
    logic instr_valid_in = 0, mem_rd_out, mem_wr_out, busy_out, done_out;
    logic [15:0] instr_word_in = 0;
    logic [11:0] frame_pointer_reg_in = 12'ha00, mem_addr_out;
    logic [7:0] mem_rdata_in = 8'h5a, mem_wdata_out;
    logic [19:0] g, v;
    logic [1:0] phase_out;
    int fails = 0, compares = 0, cyc = 0;
    iobf_exec u_dut (.*);
    always #50 clk_in = ~clk_in;
    always @(posedge clk_in) if (++cyc == 300) begin fails++; close_out(); end
    task check(input logic [19:0] got, input logic [19:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: %h %h", $time, got, exp);
        end
    endtask
    task run(input logic [15:0] w, input logic [7:0] x, input logic e);
        logic rd_seen;
        rd_seen = 1'b0;
        @(posedge clk_in) #1 {instr_word_in, instr_valid_in} = {w, 1'h1};
        for (int n = 0; n < 8 && !mem_wr_out; n++) begin
            @(posedge clk_in) #1 instr_valid_in = n < 7 && !busy_out;
            rd_seen = rd_seen | mem_rd_out;
        end
        g = mem_wr_out ? {mem_addr_out, mem_wdata_out} : 20'h0;
        v = e ? {frame_pointer_reg_in + 12'(w[7:0]), x} : 20'h0;
        check(g, v);
        check(20'({rd_seen, busy_out}), 20'({e && w[15:12] == 4'h8, e}));
        @(posedge clk_in) #1 check(20'({done_out, phase_out}), e ? 20'h6 : 20'h0);
    endtask
    task t_exec;
        for (int b = 0; b < 8; b++)
            run({4'h8, 3'(b), 1'h0, 8'(b * 13)}, 8'h5a | 8'(1 << b), 1);
        frame_pointer_reg_in = 12'hfa0;
        run(16'h685f, 8'hff, 1);
        $display("execute test done");
    endtask
    task t_refuse;
        run(16'h6860, 0, 0);
        run(16'h8101, 0, 0);
        extension_enable_bit_in = 0;
        run(16'h6810, 0, 0);
        $display("refuse test done");
    endtask
    task close_out;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk_in);
        #1 sys_rst_in = 0;
        t_exec();
        t_refuse();
        close_out();
    end
endmodule
bind iobf_exec iobf_exec_properties u_chk (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .extension_enable_bit_in(extension_enable_bit_in),
    .mem_rd_out(mem_rd_out),
    .mem_wr_out(mem_wr_out),
    .busy_out(busy_out),
    .done_out(done_out),
    .mem_rdata_in(mem_rdata_in),
    .mem_wdata_out(mem_wdata_out),
    .mem_addr_out(mem_addr_out),
    .frame_pointer_reg_in(frame_pointer_reg_in)
);
